// ==== boot_seq_map.svh ====
// Constants for the boot mode sequencer.
`ifndef BOOT_SEQ_MAP_SVH
`define BOOT_SEQ_MAP_SVH
`define BOOT_COPY_BYTES 16'h0400
`define BOOT_COPY_WORDS 16'h0100
`define BOOT_SRC_BASE 32'h9000_0000
`define BOOT_DST_BASE 32'h0000_0000
`define BOOT_RESET_PC 32'h0000_0000
`define BOOT_MODE_NONE 2'h0
`define BOOT_MODE_HOST 2'h1
`define BOOT_MODE_MEM 2'h2
`define BOOT_HOST_SEL_PARALLEL 1'h0
`define BOOT_HOST_SEL_PCI 1'h1
`endif

// ==== boot_seq_pkg.sv ====
// Types for the boot mode sequencer.
package boot_seq_pkg;
	typedef enum logic [1:0] {
		BOOT_NONE,
		BOOT_HOST,
		BOOT_MEM,
		BOOT_RSVD
	} boot_mode_type;
	typedef enum {
		ST_RESET,
		ST_HOST_WAIT,
		ST_COPY,
		ST_RUN
	} seq_state_type;
endpackage : boot_seq_pkg

// ==== byte_pack_if.sv ====
// Interface between the byte packer and the sequencer.
`timescale 1ns/100ps
interface byte_pack_if;
	logic byte_valid;
	logic [7:0] byte_data;
	logic word_valid;
	logic [31:0] word_data;
	logic clear;
	modport packer (input byte_valid, input byte_data, input clear, output word_valid, output word_data);
	modport user (output byte_valid, output byte_data, output clear, input word_valid, input word_data);
endinterface : byte_pack_if

// ==== byte_packer.sv ====
// Packs four consecutive ROM bytes into a 32-bit instruction word.
`timescale 1ns/100ps
module byte_packer (
	input wire logic clk,
	input wire logic rst,
	input wire logic big_endian,
	byte_pack_if.packer bp
);
	logic [1:0] cnt_q;
	logic [31:0] word_q;
	logic valid_q;

	// Bytes land in the lane picked by the configured byte order.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 2'h0;
			word_q <= 32'h0000_0000;
			valid_q <= 1'b0;
		end else if (bp.clear) begin
			cnt_q <= 2'h0;
			valid_q <= 1'b0;
		end else begin
			valid_q <= bp.byte_valid && (cnt_q == 2'h3);
			if (bp.byte_valid) begin
				cnt_q <= cnt_q + 2'h1;
				if (big_endian) begin
					word_q[8*(3-cnt_q) +: 8] <= bp.byte_data;
				end else begin
					word_q[8*cnt_q +: 8] <= bp.byte_data;
				end
			end
		end
	end

	assign bp.word_valid = valid_q;
	assign bp.word_data = word_q;

	// One word follows every fourth accepted byte, one cycle later.
	word_after_four_a: assert property (@(posedge clk) disable iff (rst)
		bp.word_valid |-> $past(bp.byte_valid) && $past(cnt_q) == 2'h3) else $error("word without four bytes");
endmodule : byte_packer

// ==== boot_mode_sequencer.sv ====
// Reset and boot mode sequencer that stalls, loads and releases the CPU.
// Function
// - Hold device in reset while reset high.
// - On release, start with sampled boot mode.
// - Host boot stalls CPU, releases other logic.
// - Host select 0 parallel, 1 PCI port.
// - Host may write and read all memory.
// - Interrupt bit unstalls CPU at address 0.
// - Boot interrupt is never latched as pending.
// - Interrupt releases stall only in host boot.
// - No further interrupts until software clears bit.
// - Memory boot copies 1K ROM to zero.
// - Pack 8-bit ROM bytes into 32-bit words.
// - Copy runs as one single-frame block.
// - Copy completion releases stall at address 0.
// - No boot runs immediately from address 0.
`timescale 1ns/100ps
`include "boot_seq_map.svh"
module boot_mode_sequencer
	import boot_seq_pkg::*;
#(
	parameter int COPY_WORDS = `BOOT_COPY_WORDS
) (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic [1:0] BOOT_MODE_SEL,
	input wire logic HOST_PORT_SEL,
	input wire logic BIG_ENDIAN,
	input wire logic HOST_TO_CPU_INTERRUPT_SET,
	input wire logic HOST_TO_CPU_INTERRUPT_CLR,
	input wire logic ROM_BYTE_VALID,
	input wire logic [7:0] ROM_BYTE_DATA,
	output logic ROM_BYTE_READY,
	output logic [31:0] ROM_ADDR,
	output logic MEM_WR_EN,
	output logic [31:0] MEM_WR_ADDR,
	output logic [31:0] MEM_WR_DATA,
	output logic PERIPH_RESET,
	output logic CPU_STALL,
	output logic [31:0] CPU_START_PC,
	output logic PARALLEL_HOST_PORT_EN,
	output logic PCI_PORT_EN,
	output logic HOST_MEM_ACCESS_EN,
	output logic HOST_TO_CPU_INTERRUPT,
	output logic CPU_INT_PENDING
);
	seq_state_type state_q;
	boot_mode_type mode_q;
	logic host_sel_q;
	logic sampled_q;
	logic int_bit_q;
	logic pending_q;
	logic [15:0] byte_cnt_q;
	logic [15:0] word_cnt_q;
	logic copy_done;
	byte_pack_if bp ();

	// The running test is needed by the flag logic, the stall and the host path alike.
	function automatic logic cpu_running(input seq_state_type s);
		return s == ST_RUN;
	endfunction : cpu_running

	byte_packer u_packer (
		.clk(CORE_CLK),
		.rst(RST),
		.big_endian(BIG_ENDIAN),
		.bp(bp)
	);

	// Straps are caught one clock after release, never under the asynchronous reset.
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			sampled_q <= 1'b0;
			mode_q <= BOOT_NONE;
			host_sel_q <= 1'b0;
		end else if (!sampled_q) begin
			sampled_q <= 1'b1;
			mode_q <= boot_mode_type'(BOOT_MODE_SEL);
			host_sel_q <= HOST_PORT_SEL;
		end
	end

	assign copy_done = bp.word_valid && (word_cnt_q == 16'(COPY_WORDS - 1));

	// Main sequence; a reserved mode code behaves as no boot.
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			state_q <= ST_RESET;
		end else begin
			unique case (state_q)
				ST_RESET: begin
					if (sampled_q) begin
						unique case (mode_q)
							BOOT_HOST: state_q <= ST_HOST_WAIT;
							BOOT_MEM: state_q <= ST_COPY;
							default: state_q <= ST_RUN;
						endcase
					end
				end
				ST_HOST_WAIT: begin
					if (int_bit_q && mode_q == BOOT_HOST) begin
						state_q <= ST_RUN;
					end
				end
				ST_COPY: begin
					if (copy_done) begin
						state_q <= ST_RUN;
					end
				end
				ST_RUN: state_q <= ST_RUN;
			endcase
		end
	end

	// Host-to-CPU bit: set wins over clear; a set while the bit stands is refused.
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			int_bit_q <= 1'b0;
		end else if (HOST_TO_CPU_INTERRUPT_SET && !int_bit_q) begin
			int_bit_q <= 1'b1;
		end else if (HOST_TO_CPU_INTERRUPT_CLR && cpu_running(state_q)) begin
			int_bit_q <= 1'b0;
		end
	end

	// Only a set seen while the CPU runs becomes a pending interrupt.
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			pending_q <= 1'b0;
		end else if (HOST_TO_CPU_INTERRUPT_SET && !int_bit_q && cpu_running(state_q)) begin
			pending_q <= 1'b1;
		end else if (HOST_TO_CPU_INTERRUPT_CLR) begin
			pending_q <= 1'b0;
		end
	end

	// Single-frame block copy: byte address walks up, word address follows packed words.
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			byte_cnt_q <= 16'h0000;
			word_cnt_q <= 16'h0000;
			MEM_WR_EN <= 1'b0;
			MEM_WR_ADDR <= 32'h0000_0000;
			MEM_WR_DATA <= 32'h0000_0000;
		end else begin
			MEM_WR_EN <= 1'b0;
			if (ROM_BYTE_VALID && ROM_BYTE_READY) begin
				byte_cnt_q <= byte_cnt_q + 16'h0001;
			end
			if (state_q == ST_COPY && bp.word_valid) begin
				MEM_WR_EN <= 1'b1;
				MEM_WR_ADDR <= `BOOT_DST_BASE + {14'h0000, word_cnt_q, 2'h0};
				MEM_WR_DATA <= bp.word_data;
				word_cnt_q <= word_cnt_q + 16'h0001;
			end
		end
	end

	// Ready drops by itself once the whole image is taken, so a ROM that keeps valid high cannot overrun.
	assign ROM_BYTE_READY = (state_q == ST_COPY) && (byte_cnt_q < 16'(COPY_WORDS * 4));
	assign ROM_ADDR = `BOOT_SRC_BASE + {16'h0000, byte_cnt_q};
	assign bp.byte_valid = ROM_BYTE_VALID && ROM_BYTE_READY;
	assign bp.byte_data = ROM_BYTE_DATA;
	assign bp.clear = (state_q != ST_COPY);

	// Everything but the CPU leaves reset with the pin; the CPU waits for the boot path to finish.
	assign PERIPH_RESET = RST;
	assign CPU_STALL = !cpu_running(state_q);
	assign CPU_START_PC = `BOOT_RESET_PC;
	assign HOST_MEM_ACCESS_EN = (state_q == ST_HOST_WAIT) || cpu_running(state_q);
	assign PARALLEL_HOST_PORT_EN = HOST_MEM_ACCESS_EN && (host_sel_q == `BOOT_HOST_SEL_PARALLEL);
	assign PCI_PORT_EN = HOST_MEM_ACCESS_EN && (host_sel_q == `BOOT_HOST_SEL_PCI);
	assign HOST_TO_CPU_INTERRUPT = int_bit_q;
	assign CPU_INT_PENDING = pending_q;

	// In the reset state nothing may run, write to memory or open the host path.
	stall_in_reset_a: assert property (@(posedge CORE_CLK)
		state_q == ST_RESET |-> CPU_STALL && !MEM_WR_EN && !HOST_MEM_ACCESS_EN && !CPU_INT_PENDING)
		else $error("CPU not stalled in reset");

	// The straps caught at release are those on the pins then, and they stay put afterwards.
	strap_sample_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		$rose(sampled_q) |-> mode_q == $past(BOOT_MODE_SEL) && host_sel_q == $past(HOST_PORT_SEL))
		else $error("strap not taken at release");
	mode_hold_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		sampled_q |=> $stable(mode_q) && $stable(host_sel_q))
		else $error("strap changed");

	// Host boot holds the stall until the bit stands, then lets go one cycle later.
	host_stall_hold_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		state_q == ST_HOST_WAIT && !int_bit_q |=> CPU_STALL)
		else $error("host boot unstalled early");
	host_release_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		state_q == ST_HOST_WAIT && int_bit_q |=> !CPU_STALL)
		else $error("host bit did not release");
	port_route_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		HOST_MEM_ACCESS_EN |-> (PCI_PORT_EN == host_sel_q) && (PARALLEL_HOST_PORT_EN == !host_sel_q))
		else $error("wrong host port");

	// The boot interrupt arrives under the stall and must never turn into a pending one.
	no_pending_boot_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		CPU_STALL |=> !CPU_INT_PENDING || $past(CPU_INT_PENDING))
		else $error("boot interrupt latched");
	pend_run_only_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		$rose(CPU_INT_PENDING) |-> $past(state_q) == ST_RUN)
		else $error("pending set outside run");
	bit_refuse_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		int_bit_q && state_q != ST_RUN |=> int_bit_q)
		else $error("bit cleared while stalled");

	// Memory boot: only the last packed word ends the stall, whatever the host bit does.
	mem_stall_hold_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		state_q == ST_COPY && !copy_done |=> CPU_STALL)
		else $error("copy stall ended early");
	copy_stall_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		MEM_WR_EN |-> CPU_STALL || $past(copy_done))
		else $error("copy write while running");
	copy_addr_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		MEM_WR_EN |-> MEM_WR_ADDR[1:0] == 2'h0 && (MEM_WR_ADDR - `BOOT_DST_BASE) < 32'(COPY_WORDS * 4))
		else $error("copy write outside image");
	copy_word_write_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		state_q == ST_COPY && bp.word_valid |=> MEM_WR_EN && MEM_WR_DATA == $past(bp.word_data))
		else $error("packed word not written");
	mem_copy_release_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		state_q == ST_COPY && copy_done |=> !CPU_STALL)
		else $error("copy end did not release");

	// No boot runs from the second edge after release.
	no_boot_run_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		$rose(sampled_q) && mode_q == BOOT_NONE |=> !CPU_STALL)
		else $error("no boot stalled");
endmodule : boot_mode_sequencer

// ==== boot_rom_model.sv ====
// Byte-wide boot ROM model that answers promptly or every other cycle.
`timescale 1ns/100ps
module boot_rom_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic slow,
	input wire logic [31:0] addr,
	input wire logic ready,
	output logic valid,
	output logic [7:0] data
);
	logic valid_q;
	logic [7:0] junk_q;
	// A slow ROM drops valid for one cycle after each byte taken, as a long access would.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			valid_q <= 1'h0;
			junk_q <= 8'h00;
		end else begin
			valid_q <= !(slow && valid_q && ready);
			junk_q <= junk_q + 8'h3B;
		end
	end
	// Contents depend only on the address; between bytes the lines carry a changing pattern.
	assign valid = valid_q;
	assign data = valid_q ? (addr[7:0] ^ 8'h5A) : junk_q;
endmodule : boot_rom_model

// ==== tb_boot_mode_sequencer.sv ====
// Self-checking bench for the boot mode sequencer.
`timescale 1ns/100ps
module tb_boot_mode_sequencer;
	logic clk = 1'h0, rst = 1'h1, sel = 1'h0, be = 1'h0, iset = 1'h0, iclr = 1'h0, slow = 1'h0;
	logic [1:0] mode = 2'h0;
	logic rv, rr, wen, prst, stall, pen, cen, hen, ibit, pend;
	logic [7:0] rd;
	logic [31:0] ra, wa, wd, pc;
	int n_mismatch = 0, checks_done = 0, cyc = 0;
	boot_mode_sequencer #(.COPY_WORDS(4)) dut (.CORE_CLK(clk), .RST(rst), .BOOT_MODE_SEL(mode),
		.HOST_PORT_SEL(sel), .BIG_ENDIAN(be), .HOST_TO_CPU_INTERRUPT_SET(iset),
		.HOST_TO_CPU_INTERRUPT_CLR(iclr), .ROM_BYTE_VALID(rv), .ROM_BYTE_DATA(rd), .ROM_BYTE_READY(rr),
		.ROM_ADDR(ra), .MEM_WR_EN(wen), .MEM_WR_ADDR(wa), .MEM_WR_DATA(wd), .PERIPH_RESET(prst),
		.CPU_STALL(stall), .CPU_START_PC(pc), .PARALLEL_HOST_PORT_EN(pen), .PCI_PORT_EN(cen),
		.HOST_MEM_ACCESS_EN(hen), .HOST_TO_CPU_INTERRUPT(ibit), .CPU_INT_PENDING(pend));
	boot_rom_model rom (.clk(clk), .rst(rst), .slow(slow), .addr(ra), .ready(rr), .valid(rv), .data(rd));
	// The clock runs at 10 MHz.
	always #50 clk = ~clk;
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	// Resets with the given straps, then flips mode and host select so a late strap change would show.
	task automatic boot(input logic [1:0] m, input logic s, input logic b);
		@(posedge clk);
		mode <= m;
		sel <= s;
		be <= b;
		rst <= 1'h1;
		repeat (3) @(posedge clk);
		chk("stall_in_reset", stall, 32'h1);
		chk("periph_in_reset", prst, 32'h1);
		rst <= 1'h0;
		repeat (3) @(posedge clk);
		mode <= ~m;
		sel <= ~s;
		#1;
	endtask : boot
	// One set or clear pulse from the host or CPU side, then time for the answer to land.
	task automatic drive(input logic s, input logic c);
		@(posedge clk);
		iset <= s;
		iclr <= c;
		@(posedge clk);
		iset <= 1'h0;
		iclr <= 1'h0;
		repeat (2) @(posedge clk);
		#1;
	endtask : drive
	task automatic t_none(input logic [1:0] m);
		boot(m, 1'h0, 1'h0);
		chk("stall_none", stall, 32'h0);
		chk("pc_none", pc, 32'h0);
		chk("periph_none", prst, 32'h0);
	endtask : t_none
	task automatic t_host(input logic s);
		boot(2'h1, s, 1'h0);
		repeat (5) @(posedge clk);
		#1;
		chk("stall_host", stall, 32'h1);
		chk("periph_host", prst, 32'h0);
		chk("pci_en", cen, {31'h0, s});
		chk("par_en", pen, {31'h0, !s});
		chk("host_mem", hen, 32'h1);
		drive(1'h0, 1'h1);
		chk("stall_clr", stall, 32'h1);
		drive(1'h1, 1'h0);
		chk("stall_rel", stall, 32'h0);
		chk("pc_host", pc, 32'h0);
		chk("pend_boot", pend, 32'h0);
		drive(1'h1, 1'h0);
		chk("pend_again", pend, 32'h0);
		drive(1'h0, 1'h1);
		chk("bit_clr", ibit, 32'h0);
		drive(1'h1, 1'h0);
		chk("bit_new", ibit, 32'h1);
		chk("pend_new", pend, 32'h1);
	endtask : t_host
	// Memory boot with a stray host interrupt at the start, which must not end the stall.
	task automatic t_mem(input logic b, input logic sl);
		int k;
		logic [31:0] e;
		logic [7:0] b8;
		k = 0;
		slow <= sl;
		boot(2'h2, 1'h0, b);
		for (int j = 0; j < 200 && k < 4; j++) begin
			@(posedge clk);
			iset <= (j == 0);
			iclr <= (j == 2);
			#1;
			if (wen === 1'h1) begin
				e = 32'h0;
				for (int i = 0; i < 4; i++) begin
					b8 = 8'(4 * k + i) ^ 8'h5A;
					e = b ? {e[23:0], b8} : {b8, e[31:8]};
				end
				chk("wr_addr", wa, 32'(4 * k));
				chk("wr_data", wd, e);
				k++;
			end
			chk("stall_mem", stall, {31'h0, k < 4});
		end
		chk("words", k, 32'h4);
		chk("bit_kept", ibit, 32'h1);
		chk("pend_mem", pend, 32'h0);
		chk("rom_ready_end", rr, 32'h0);
		chk("rom_addr_end", ra, 32'h9000_0010);
	endtask : t_mem
	// A hang is cut short well beyond the roughly 150 cycles the run needs.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	initial begin
		t_none(2'h0);
		t_none(2'h3);
		t_host(1'h0);
		t_host(1'h1);
		t_mem(1'h0, 1'h1);
		t_mem(1'h1, 1'h0);
		give_verdict();
	end
endmodule : tb_boot_mode_sequencer
